/* core/cursor_test_pkg.sv */
// Shared constants and types for the cursor, cross-hair and signature test block
package cursor_test_pkg;
  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [4:0] IDX_RED_SIG = 5'h00;
  localparam logic [4:0] IDX_GREEN_SIG = 5'h01;
  localparam logic [4:0] IDX_BLUE_SIG = 5'h02;
  localparam logic [4:0] IDX_SELF_TEST = 5'h03;
  localparam logic [4:0] IDX_CURSOR_CTL = 5'h04;
  localparam logic [4:0] IDX_CURSOR_POS = 5'h05;
  localparam logic [4:0] IDX_WINDOW_POS = 5'h09;
  localparam logic [4:0] IDX_WINDOW_SIZE = 5'h0D;
  // Byte order inside a staged group: x low, x high, y low, y high
  localparam logic [1:0] BYTE_Y_HIGH = 2'h3;
  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int TEST_RESULT_BIT = 3;
  localparam int TEST_SEL_LSB = 4;
  localparam int CTL_BIG_P1 = 7;
  localparam int CTL_BIG_P0 = 6;
  localparam int CTL_CH_P1 = 5;
  localparam int CTL_CH_P0 = 4;
  localparam int CTL_COMBINE = 3;
  localparam int CTL_THICK_LSB = 1;
  localparam int CTL_BLINK = 0;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [11:0] POS_RESET = 12'h000;
  localparam logic [23:0] SIG_RESET = 24'h00_0000;
  // ----------------------------------------------------------------
  // Geometry and pipeline figures
  // ----------------------------------------------------------------
  localparam logic [13:0] CURSOR_HALF = 14'h0020;
  localparam logic [5:0] NEG_Y_TOP = 6'h3F;
  localparam logic [12:0] WIN_EXTRA_1 = 13'h0002;
  localparam logic [12:0] WIN_EXTRA_4 = 13'h0008;
  localparam logic [12:0] WIN_EXTRA_5 = 13'h000A;
  localparam logic [12:0] WIN_EXTRA_H = 13'h0002;
  localparam logic [11:0] CUR_OFS_1 = 12'h025;
  localparam logic [11:0] CUR_OFS_4 = 12'h034;
  localparam logic [11:0] CUR_OFS_5 = 12'h039;
  localparam logic [11:0] CUR_OFS_Y = 12'h020;
  localparam logic [11:0] WIN_OFS_1 = 12'h005;
  localparam logic [11:0] WIN_OFS_4 = 12'h014;
  localparam logic [11:0] WIN_OFS_5 = 12'h019;
  localparam logic [11:0] FULL_SCREEN = 12'h0FFF;
  localparam logic [2:0] PIXEL_A = 3'h0;
  localparam logic [2:0] PIXEL_E = 3'h4;
  localparam int PIXELS = 5;
  localparam logic [23:0] SIG_TAPS = 24'hE1_0000;

  typedef enum logic [1:0] {MUX_1, MUX_4, MUX_5} mux_mode_type;
endpackage

/* core/cursor_test_if.sv */
// Host and pixel-source signals joining the two ends
`timescale 1ns/1ps
interface cursor_test_if;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic [7:0] reg_rdata;
  logic hsync;
  logic vretrace;
  logic blank_n;
  logic pixel_load_strobe;
  logic [4:0][23:0] pixel_rgb;

  modport device (
    input reg_addr,
    input reg_wdata,
    input reg_wr,
    output reg_rdata,
    input hsync,
    input vretrace,
    input blank_n,
    input pixel_load_strobe,
    input pixel_rgb
  );
  modport host (
    output reg_addr,
    output reg_wdata,
    output reg_wr,
    input reg_rdata,
    output hsync,
    output vretrace,
    output blank_n,
    output pixel_load_strobe,
    output pixel_rgb
  );
endinterface

/* core/staged_pair.sv */
// Pair of 12-bit values written bytewise and applied at vertical retrace
`timescale 1ns/1ps
module staged_pair
  import cursor_test_pkg::*;
#(
  parameter logic [4:0] BASE = 5'h00
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic vretrace,
  output logic hit,
  output logic [7:0] rd_byte,
  output logic [11:0] cur_x,
  output logic [11:0] cur_y
);
  if (BASE > 5'h1B) $error("staged_pair base out of range");

  typedef struct packed {
    logic [11:0] x;
    logic [11:0] y;
    logic [11:0] ax;
    logic [11:0] ay;
    logic pend;
  } pair_state_type;

  pair_state_type st_reg, st_next;
  logic [4:0] ofs;
  logic [1:0] sel;

  assign ofs = reg_addr - BASE;
  assign sel = ofs[1:0];
  assign hit = (reg_addr >= BASE) && (ofs < 5'h04);
  assign cur_x = st_reg.ax;
  assign cur_y = st_reg.ay;

  always_comb begin
    unique case (sel)
      2'h0: rd_byte = st_reg.x[7:0];
      2'h1: rd_byte = {4'h0, st_reg.x[11:8]};
      2'h2: rd_byte = st_reg.y[7:0];
      default: rd_byte = {4'h0, st_reg.y[11:8]};
    endcase
  end

  always_comb begin
    st_next = st_reg;
    if (hit && reg_wr) begin
      unique case (sel)
        2'h0: st_next.x[7:0] = reg_wdata;
        2'h1: st_next.x[11:8] = reg_wdata[3:0];
        2'h2: st_next.y[7:0] = reg_wdata;
        default: st_next.y[11:8] = reg_wdata[3:0];
      endcase
    end
    // Pending is set by the high y byte; a fresh write beats the retrace clear
    if (st_reg.pend && vretrace) begin
      st_next.ax = st_reg.x;
      st_next.ay = st_reg.y;
      st_next.pend = 1'b0;
    end
    if (hit && reg_wr && sel == BYTE_Y_HIGH) begin
      st_next.pend = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

/* core/cursor_test_device.sv */
// Cursor, cross-hair window and signature test logic of the video converter
`timescale 1ns/1ps
module cursor_test_device
  import cursor_test_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  cursor_test_if.device link,
  input wire mux_mode_type mux_mode,
  input wire logic test_method_select,
  input wire logic blink_phase,
  input wire logic dac_compare_in,
  input wire logic [1:0] cursor_ram_pattern,
  output logic [11:0] cursor_ram_addr,
  output logic [3:0] dac_compare_select,
  output logic [1:0] cursor_planes
);
  typedef struct packed {
    logic [23:0] sig;
    logic [7:0] test;
    logic [7:0] ctl;
    logic [11:0] x_cnt;
    logic [11:0] y_cnt;
    logic hsync_d;
    logic [1:0] planes;
    logic [1:0] cmp_sync;
  } dev_state_type;

  dev_state_type st_reg, st_next;

  logic [11:0] cx, cy, wx, wy, ww, wh;
  logic [7:0] cpos_byte, wpos_byte, wsize_byte;
  logic cpos_hit, wpos_hit, wsize_hit;

  // ----------------------------------------------------------------
  // Staged position and size registers
  // ----------------------------------------------------------------
  staged_pair #(.BASE(IDX_CURSOR_POS)) u_cursor_pos (
    .clk(clk),
    .sys_rst(sys_rst),
    .reg_addr(link.reg_addr),
    .reg_wdata(link.reg_wdata),
    .reg_wr(link.reg_wr),
    .vretrace(link.vretrace),
    .hit(cpos_hit),
    .rd_byte(cpos_byte),
    .cur_x(cx),
    .cur_y(cy)
  );

  staged_pair #(.BASE(IDX_WINDOW_POS)) u_window_pos (
    .clk(clk),
    .sys_rst(sys_rst),
    .reg_addr(link.reg_addr),
    .reg_wdata(link.reg_wdata),
    .reg_wr(link.reg_wr),
    .vretrace(link.vretrace),
    .hit(wpos_hit),
    .rd_byte(wpos_byte),
    .cur_x(wx),
    .cur_y(wy)
  );

  staged_pair #(.BASE(IDX_WINDOW_SIZE)) u_window_size (
    .clk(clk),
    .sys_rst(sys_rst),
    .reg_addr(link.reg_addr),
    .reg_wdata(link.reg_wdata),
    .reg_wr(link.reg_wr),
    .vretrace(link.vretrace),
    .hit(wsize_hit),
    .rd_byte(wsize_byte),
    .cur_x(ww),
    .cur_y(wh)
  );

  // ----------------------------------------------------------------
  // Register read path
  // ----------------------------------------------------------------
  always_comb begin
    link.reg_rdata = REG_RESET;
    if (link.reg_addr == IDX_RED_SIG) begin
      link.reg_rdata = st_reg.sig[23:16];
    end else if (link.reg_addr == IDX_GREEN_SIG) begin
      link.reg_rdata = st_reg.sig[15:8];
    end else if (link.reg_addr == IDX_BLUE_SIG) begin
      link.reg_rdata = st_reg.sig[7:0];
    end else if (link.reg_addr == IDX_SELF_TEST) begin
      link.reg_rdata = st_reg.test;
    end else if (link.reg_addr == IDX_CURSOR_CTL) begin
      link.reg_rdata = st_reg.ctl;
    end else if (cpos_hit) begin
      link.reg_rdata = cpos_byte;
    end else if (wpos_hit) begin
      link.reg_rdata = wpos_byte;
    end else if (wsize_hit) begin
      link.reg_rdata = wsize_byte;
    end
  end

  // ----------------------------------------------------------------
  // Raster geometry
  // ----------------------------------------------------------------
  logic [13:0] xs, ys, cxs, cys, dx, dy, hx, hy, ax, ay, half;
  logic [12:0] wext, x_end, y_end;
  logic in_big, in_win, on_ch, ch_px, big_shown, ch_shown;
  logic [1:0] big_px, ch_planes, mixed;
  logic [2:0] pick;
  logic [23:0] sample, lfsr;

  always_comb begin
    xs = {2'b00, st_reg.x_cnt};
    ys = {2'b00, st_reg.y_cnt};
    cxs = {2'b00, cx};
    // Top 64 codes of cursor y are negative so the cursor can sit above line 0
    cys = (cy[11:6] == NEG_Y_TOP) ? {2'b11, cy} : {2'b00, cy};
    dx = xs - cxs + CURSOR_HALF;
    dy = ys - cys + CURSOR_HALF;
    in_big = (dx[13:6] == 8'h00) && (dy[13:6] == 8'h00);
    hx = xs - cxs;
    hy = ys - cys;
    ax = hx[13] ? 14'(-hx) : hx;
    ay = hy[13] ? 14'(-hy) : hy;
    half = {12'h000, st_reg.ctl[CTL_THICK_LSB +: 2]};
    on_ch = (ax <= half) || (ay <= half);
    unique case (mux_mode)
      MUX_4: wext = WIN_EXTRA_4;
      MUX_5: wext = WIN_EXTRA_5;
      default: wext = WIN_EXTRA_1;
    endcase
    x_end = {1'b0, ww} + wext;
    y_end = {1'b0, wh} + WIN_EXTRA_H;
    // Offset into the window is compared, so a large corner plus size cannot wrap
    in_win = (st_reg.x_cnt >= wx) && ({1'b0, 12'(st_reg.x_cnt - wx)} < x_end) &&
             (st_reg.y_cnt >= wy) && ({1'b0, 12'(st_reg.y_cnt - wy)} < y_end);
    ch_px = on_ch && in_win;
    big_px = in_big ? (cursor_ram_pattern &
             {st_reg.ctl[CTL_BIG_P1], st_reg.ctl[CTL_BIG_P0]}) : 2'b00;
    ch_planes = {ch_px & st_reg.ctl[CTL_CH_P1], ch_px & st_reg.ctl[CTL_CH_P0]};
    big_shown = st_reg.ctl[CTL_BIG_P1] | st_reg.ctl[CTL_BIG_P0];
    ch_shown = st_reg.ctl[CTL_CH_P1] | st_reg.ctl[CTL_CH_P0];
    if (big_shown && ch_shown) begin
      mixed = st_reg.ctl[CTL_COMBINE] ? (big_px | ch_planes) : (big_px ^ ch_planes);
    end else begin
      mixed = big_px | ch_planes;
    end
    if (st_reg.ctl[CTL_BLINK] && !blink_phase) begin
      mixed = 2'b00;
    end
  end

  assign cursor_ram_addr = {dy[5:0], dx[5:0]};
  assign cursor_planes = st_reg.planes;
  assign dac_compare_select = st_reg.test[TEST_SEL_LSB +: 4];

  // ----------------------------------------------------------------
  // Signature sampling
  // ----------------------------------------------------------------
  always_comb begin
    // Reserved codes fall back to pixel A; 1:1 always feeds pixel A
    pick = (st_reg.test[2:0] > PIXEL_E) ? PIXEL_A : st_reg.test[2:0];
    if (mux_mode == MUX_1) begin
      pick = PIXEL_A;
    end
    sample = link.pixel_rgb[pick];
    lfsr = {st_reg.sig[22:0], ^(st_reg.sig & SIG_TAPS)};
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.hsync_d = link.hsync;
    // The comparator is analog and not tied to this clock, so it is synchronised first
    st_next.cmp_sync = {st_reg.cmp_sync[0], dac_compare_in};
    st_next.planes = mixed;
    st_next.x_cnt = link.hsync ? POS_RESET : 12'(st_reg.x_cnt + 12'h001);
    if (link.vretrace) begin
      st_next.y_cnt = POS_RESET;
    end else if (link.hsync && !st_reg.hsync_d) begin
      st_next.y_cnt = 12'(st_reg.y_cnt + 12'h001);
    end
    if (link.reg_wr && link.reg_addr == IDX_CURSOR_CTL) begin
      st_next.ctl = link.reg_wdata;
    end
    if (link.reg_wr && link.reg_addr == IDX_SELF_TEST) begin
      st_next.test = {link.reg_wdata[7:4], st_reg.test[TEST_RESULT_BIT],
                      link.reg_wdata[2:0]};
    end
    // Left edge of the cursor area: one strobe per frame when the line matches
    if (dx == 14'h0000 && dy[13:6] == 8'h00 && dy[5:0] == 6'h00) begin
      st_next.test[TEST_RESULT_BIT] = st_reg.cmp_sync[1];
    end
    if (!link.blank_n) begin
      if (link.reg_wr && link.reg_addr == IDX_RED_SIG) begin
        st_next.sig[23:16] = link.reg_wdata;
      end
      if (link.reg_wr && link.reg_addr == IDX_GREEN_SIG) begin
        st_next.sig[15:8] = link.reg_wdata;
      end
      if (link.reg_wr && link.reg_addr == IDX_BLUE_SIG) begin
        st_next.sig[7:0] = link.reg_wdata;
      end
    end else if (link.pixel_load_strobe) begin
      if (test_method_select) begin
        st_next.sig = sample;
      end else begin
        st_next.sig = lfsr ^ sample;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

/* core/cursor_test_host.sv */
// Host processor and pixel source end: register sequencer and raster timing
`timescale 1ns/1ps
module cursor_test_host
  import cursor_test_pkg::*;
#(
  parameter int H_TOTAL = 64,
  parameter int H_ACTIVE = 48,
  parameter int V_TOTAL = 40,
  parameter int V_ACTIVE = 32,
  parameter logic [11:0] H_SYNC_TO_ACTIVE = 12'h010,
  parameter logic [11:0] V_SYNC_TO_ACTIVE = 12'h004
) (
  input wire logic clk,
  input wire logic sys_rst,
  cursor_test_if.host link,
  input wire mux_mode_type mux_mode,
  input wire logic normal_display,
  input wire logic req_valid,
  input wire logic [1:0] req_kind,
  input wire logic [4:0] req_addr,
  input wire logic [11:0] req_x,
  input wire logic [11:0] req_y,
  output logic req_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  input wire logic [4:0][23:0] pixel_in
);
  if (H_ACTIVE >= H_TOTAL || V_ACTIVE >= V_TOTAL || H_TOTAL > 4095 || V_TOTAL > 4095)
    $error("cursor_test_host raster parameters invalid");

  // Request kinds: 0 raw write, 1 raw read, 2 place cursor, 3 place window
  typedef enum logic [1:0] {IDLE, SEND, FINISH} host_fsm_type;
  typedef struct packed {
    host_fsm_type fsm;
    logic [3:0][7:0] q;
    logic [4:0] base;
    logic [1:0] step;
    logic [1:0] last;
    logic rd;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic [11:0] h;
    logic [11:0] v;
    logic [2:0] div;
    logic [4:0][23:0] pix;
  } host_state_type;

  host_state_type st_reg, st_next;
  logic [11:0] px, py, ofs;
  logic [7:0] wbyte;
  logic [2:0] div_top;

  always_comb begin
    unique case (mux_mode)
      MUX_4: ofs = (req_kind == 2'h2) ? CUR_OFS_4 : WIN_OFS_4;
      MUX_5: ofs = (req_kind == 2'h2) ? CUR_OFS_5 : WIN_OFS_5;
      default: ofs = (req_kind == 2'h2) ? CUR_OFS_1 : WIN_OFS_1;
    endcase
    px = req_x + H_SYNC_TO_ACTIVE - ofs;
    py = req_y + V_SYNC_TO_ACTIVE - ((req_kind == 2'h2) ? CUR_OFS_Y : 12'h000);
    div_top = (mux_mode == MUX_4) ? 3'h3 : ((mux_mode == MUX_5) ? 3'h4 : 3'h0);
    wbyte = st_reg.q[st_reg.step];
    if (st_reg.base == IDX_SELF_TEST) begin
      if (mux_mode == MUX_1) begin
        wbyte[2:0] = PIXEL_A;
      end
      if (normal_display) begin
        wbyte[7:3] = 5'h00;
      end
    end
  end

  assign req_ready = (st_reg.fsm == IDLE);
  assign rsp_valid = st_reg.rsp_valid;
  assign rsp_data = st_reg.rsp_data;
  assign link.reg_addr = 5'(st_reg.base + {3'h0, st_reg.step});
  assign link.reg_wdata = wbyte;
  assign link.reg_wr = (st_reg.fsm == SEND) && !st_reg.rd;
  assign link.hsync = (st_reg.h >= 12'(H_TOTAL - 4));
  assign link.vretrace = (st_reg.v >= 12'(V_ACTIVE));
  assign link.blank_n = (st_reg.h < 12'(H_ACTIVE)) && (st_reg.v < 12'(V_ACTIVE));
  assign link.pixel_load_strobe = (st_reg.div == 3'h0);
  assign link.pixel_rgb = st_reg.pix;

  always_comb begin
    st_next = st_reg;
    st_next.rsp_valid = 1'b0;
    st_next.h = (st_reg.h == 12'(H_TOTAL - 1)) ? 12'h000 : 12'(st_reg.h + 12'h001);
    if (st_reg.h == 12'(H_TOTAL - 1)) begin
      st_next.v = (st_reg.v == 12'(V_TOTAL - 1)) ? 12'h000 : 12'(st_reg.v + 12'h001);
    end
    st_next.div = (st_reg.div >= div_top) ? 3'h0 : 3'(st_reg.div + 3'h1);
    if (st_reg.div >= div_top) begin
      st_next.pix = pixel_in;
    end
    unique case (st_reg.fsm)
      IDLE: begin
        if (req_valid) begin
          st_next.fsm = SEND;
          st_next.step = 2'h0;
          st_next.rd = (req_kind == 2'h1);
          st_next.base = req_addr;
          st_next.last = 2'h0;
          st_next.q = {4{req_x[7:0]}};
          if (req_kind[1]) begin
            // Full 12-bit bytes, y high last so the move arms only once
            st_next.base = (req_kind == 2'h2) ? IDX_CURSOR_POS : IDX_WINDOW_POS;
            st_next.q = {{4'h0, py[11:8]}, py[7:0], {4'h0, px[11:8]}, px[7:0]};
            st_next.last = BYTE_Y_HIGH;
          end
        end
      end
      SEND: begin
        if (st_reg.rd) begin
          st_next.rsp_data = link.reg_rdata;
        end
        if (st_reg.step == st_reg.last) begin
          st_next.fsm = FINISH;
        end else begin
          st_next.step = 2'(st_reg.step + 2'h1);
        end
      end
      FINISH: begin
        st_next.rsp_valid = 1'b1;
        st_next.fsm = IDLE;
      end
      default: begin
        st_next.fsm = IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

/* dv/cursor_test_assertions.sv */
// Checker for the register and pixel link between the host and device ends
`timescale 1ns/1ps
module cursor_test_assertions
  import cursor_test_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [7:0] reg_rdata,
  input wire logic hsync,
  input wire logic vretrace,
  input wire logic blank_n,
  input wire logic pixel_load_strobe,
  input wire logic [4:0][23:0] pixel_rgb
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // Write followed by a cycle that still addresses the same register
  sequence wr_rd(logic [4:0] a);
    (reg_wr && reg_addr == a) ##1 (reg_addr == a);
  endsequence
  sequence red_quiet;
    reg_addr == IDX_RED_SIG && !(blank_n && pixel_load_strobe) && !(reg_wr && !blank_n);
  endsequence

  AST_CTL_READBACK: assert property (
    wr_rd(IDX_CURSOR_CTL) |-> reg_rdata == $past(reg_wdata))
    else $error("cursor control readback differs");
  AST_HIGH_NIBBLE: assert property (
    reg_addr inside {5'h06, 5'h08, 5'h0A, 5'h0C, 5'h0E, 5'h10} |-> reg_rdata[7:4] == 4'h0)
    else $error("high byte upper nibble not zero");
  AST_POS_HIGH: assert property (
    wr_rd(5'h08) |-> reg_rdata == {4'h0, $past(reg_wdata[3:0])})
    else $error("cursor y high readback differs");
  AST_HEIGHT_HIGH: assert property (
    wr_rd(5'h10) |-> reg_rdata == {4'h0, $past(reg_wdata[3:0])})
    else $error("window height high readback differs");
  AST_SEED: assert property (
    (reg_wr && reg_addr == IDX_GREEN_SIG && !blank_n) ##1 (reg_addr == IDX_GREEN_SIG)
    |-> reg_rdata == $past(reg_wdata))
    else $error("signature seed not loaded");
  AST_SIG_HOLD: assert property (
    red_quiet ##1 (reg_addr == IDX_RED_SIG) |-> $stable(reg_rdata))
    else $error("signature moved without a strobe");
  AST_TEST_FIELDS: assert property (
    wr_rd(IDX_SELF_TEST) |->
    {reg_rdata[7:4], reg_rdata[2:0]} == $past({reg_wdata[7:4], reg_wdata[2:0]}))
    else $error("test register fields differ");
  // Even the slowest multiplex mode leaves only four idle cycles
  AST_STROBE_GAP: assert property (
    !pixel_load_strobe [*4] |=> pixel_load_strobe)
    else $error("load strobe gap too long");
endmodule

/* dv/test_cursor_crosshair_signature_test.sv */
// Testbench joining the host and device ends across their interface
`timescale 1ns/1ps
module test_cursor_crosshair_signature_test
  import cursor_test_pkg::*;
;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  mux_mode_type mux_mode = MUX_1;
  logic normal_display = 1'b0;
  logic req_valid = 1'b0;
  logic [1:0] req_kind = 2'h0;
  logic [4:0] req_addr = 5'h00;
  logic [11:0] req_x = 12'h000;
  logic [11:0] req_y = 12'h000;
  logic req_ready;
  logic rsp_valid;
  logic [7:0] rsp_data;
  logic [4:0][23:0] pixel_in = '0;
  logic test_method_select = 1'b0;
  logic blink_phase = 1'b1;
  logic dac_compare_in = 1'b0;
  logic [1:0] cursor_ram_pattern = 2'h3;
  // Single-entry cursor RAM: only the top-left cell is set
  logic ram_mode = 1'b0;
  logic [11:0] cursor_ram_addr;
  logic [3:0] dac_compare_select;
  logic [1:0] cursor_planes;
  logic [23:0] sig_m;
  logic [23:0] px;
  logic [2:0] tsel;
  logic [7:0] cur, snap1, snap2;
  logic [7:0] cnt = 8'h00;
  int error_cnt = 0;
  int check_count = 0;
  int c [4];
  int t1;
  localparam logic [3:0] CMP [5] = '{4'h0, 4'hA, 4'h9, 4'h6, 4'h5};
  localparam mux_mode_type ML [6] = '{MUX_1, MUX_1, MUX_4, MUX_4, MUX_5, MUX_5};
  localparam logic [2:0] SL [6] = '{3'h0, 3'h0, 3'h3, 3'h5, 3'h4, 3'h1};

  cursor_test_if link();
  cursor_test_host i_cursor_test_host (.clk(clk), .sys_rst(sys_rst), .link(link),
    .mux_mode(mux_mode), .normal_display(normal_display), .req_valid(req_valid),
    .req_kind(req_kind), .req_addr(req_addr), .req_x(req_x), .req_y(req_y),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .pixel_in(pixel_in));
  cursor_test_device i_cursor_test_device (.clk(clk), .sys_rst(sys_rst), .link(link),
    .mux_mode(mux_mode), .test_method_select(test_method_select), .blink_phase(blink_phase),
    .dac_compare_in(dac_compare_in),
    .cursor_ram_pattern(ram_mode ? {2{cursor_ram_addr == 12'h000}} : cursor_ram_pattern),
    .cursor_ram_addr(cursor_ram_addr), .dac_compare_select(dac_compare_select),
    .cursor_planes(cursor_planes));
  cursor_test_assertions chk (.clk(clk), .sys_rst(sys_rst), .reg_addr(link.reg_addr),
    .reg_wdata(link.reg_wdata), .reg_wr(link.reg_wr), .reg_rdata(link.reg_rdata),
    .hsync(link.hsync), .vretrace(link.vretrace), .blank_n(link.blank_n),
    .pixel_load_strobe(link.pixel_load_strobe), .pixel_rgb(link.pixel_rgb));

  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    #1;
    cnt = cnt + 8'h01;
    for (int i = 0; i < PIXELS; i++) pixel_in[i] = {3{cnt + 8'(i * 37)}};
  end

  // ----------------------------------------------------------------
  // Signature model fed from the wire
  // ----------------------------------------------------------------
  assign px = link.pixel_rgb[(mux_mode == MUX_1 || tsel > PIXEL_E) ? PIXEL_A : tsel];
  assign cur = link.reg_addr < 5'h03 ? sig_m[16 - 8 * int'(link.reg_addr) +: 8] : 8'h00;
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sig_m <= SIG_RESET;
      tsel <= PIXEL_A;
    end else begin
      snap1 <= cur;
      snap2 <= snap1;
      if (link.reg_wr && link.reg_addr == IDX_SELF_TEST) tsel <= link.reg_wdata[2:0];
      if (link.reg_wr && !link.blank_n && link.reg_addr < 5'h03) begin
        sig_m[16 - 8 * int'(link.reg_addr) +: 8] <= link.reg_wdata;
      end else if (link.blank_n && link.pixel_load_strobe) begin
        sig_m <= test_method_select ? px : {sig_m[22:0], ^(sig_m & SIG_TAPS)} ^ px;
      end
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic req(input logic [1:0] k, input logic [4:0] a, input logic [11:0] x,
                     input logic [11:0] y);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 100) check(8'h00, 8'h01);
    req_kind = k;
    req_addr = a;
    req_x = x;
    req_y = y;
    req_valid = 1'b1;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 20) check(8'h00, 8'h01);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    req(2'h0, a, {4'h0, d}, 12'h000);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    req(2'h1, a, 12'h000, 12'h000);
    check(rsp_data, e);
  endtask
  // Counts plane codes over exactly one raster frame, so phase does not matter
  task automatic frame(input logic [7:0] ctl);
    wr(IDX_CURSOR_CTL, ctl);
    c = '{0, 0, 0, 0};
    repeat (2560) begin
      @(posedge clk);
      #1;
      c[cursor_planes]++;
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #400_000;
    error_cnt++;
    final_report;
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    #1 sys_rst = 1'b0;
    rd(IDX_CURSOR_CTL, REG_RESET);
    wr(5'h11, 8'h5A);
    rd(5'h11, 8'h00);
    wr(IDX_CURSOR_CTL, 8'hA5);
    rd(IDX_CURSOR_CTL, 8'hA5);
    wr(5'h06, 8'hFF);
    rd(5'h06, 8'h0F);
    wr(5'h0E, 8'hF3);
    rd(5'h0E, 8'h03);
    foreach (CMP[i]) begin
      wr(IDX_SELF_TEST, {CMP[i], 4'h2});
      check({4'h0, dac_compare_select}, {4'h0, CMP[i]});
      req(2'h1, IDX_SELF_TEST, 12'h000, 12'h000);
      check(rsp_data & 8'hF7, {CMP[i], 4'h0});
    end
    normal_display = 1'b1;
    wr(IDX_SELF_TEST, 8'hF9);
    req(2'h1, IDX_SELF_TEST, 12'h000, 12'h000);
    check(rsp_data & 8'hF7, 8'h00);
    normal_display = 1'b0;
    req(2'h2, 5'h00, 12'd20, 12'd10);
    rd(5'h05, 8'hFF);
    rd(5'h08, 8'h0F);
    rd(5'h07, 8'hEE);
    mux_mode = MUX_4;
    req(2'h2, 5'h00, 12'd100, 12'd40);
    rd(5'h05, 8'h40);
    mux_mode = MUX_5;
    req(2'h3, 5'h00, 12'd30, 12'd7);
    rd(5'h09, 8'h15);
    rd(5'h0B, 8'h0B);
    for (int k = 0; k < 6; k++) begin
      mux_mode = ML[k];
      wr(IDX_SELF_TEST, {5'h00, SL[k]});
      test_method_select = (k % 2 == 1);
      wr(IDX_RED_SIG, 8'h3C);
      wr(IDX_GREEN_SIG, 8'hC3);
      wr(IDX_BLUE_SIG, 8'h99);
      repeat (300) @(posedge clk);
      #1;
      for (int a = 0; a < 3; a++) begin
        req(2'h1, 5'(a), 12'h000, 12'h000);
        check(rsp_data, snap2);
      end
    end
    mux_mode = MUX_1;
    test_method_select = 1'b0;
    wr(5'h05, 8'h28);
    wr(5'h06, 8'h00);
    wr(5'h07, 8'h24);
    wr(5'h08, 8'h00);
    wr(5'h09, 8'h00);
    wr(5'h0C, 8'h00);
    foreach (CMP[i]) wr(5'h0D + 5'(i % 4), (i % 2 == 0) ? 8'hFF : 8'h0F);
    wr(IDX_SELF_TEST, 8'hA0);
    dac_compare_in = 1'b1;
    repeat (5200) @(posedge clk);
    #1;
    req(2'h1, IDX_SELF_TEST, 12'h000, 12'h000);
    check(rsp_data & 8'h08, 8'h08);
    dac_compare_in = 1'b0;
    repeat (2600) @(posedge clk);
    #1;
    req(2'h1, IDX_SELF_TEST, 12'h000, 12'h000);
    check(rsp_data & 8'h08, 8'h00);
    wr(IDX_SELF_TEST, 8'h00);
    frame(8'h00);
    check({7'h0, c[0] == 2560}, 8'h01);
    frame(8'h40);
    check({7'h0, c[2] == 0 && c[3] == 0 && c[1] > 0}, 8'h01);
    frame(8'h80);
    check({7'h0, c[1] == 0 && c[3] == 0 && c[2] > 0}, 8'h01);
    cursor_ram_pattern = 2'h0;
    frame(8'h30);
    t1 = c[3];
    check({7'h0, c[1] == 0 && c[2] == 0 && t1 > 0}, 8'h01);
    frame(8'h36);
    check({7'h0, c[3] > t1}, 8'h01);
    cursor_ram_pattern = 2'h3;
    frame(8'hF0);
    t1 = c[0];
    frame(8'hF8);
    check({7'h0, c[0] < t1}, 8'h01);
    blink_phase = 1'b0;
    frame(8'hF9);
    check({7'h0, c[0] == 2560}, 8'h01);
    blink_phase = 1'b1;
    ram_mode = 1'b1;
    frame(8'hC0);
    check({7'h0, c[3] == 1}, 8'h01);
    ram_mode = 1'b0;
    cursor_ram_pattern = 2'h0;
    frame(8'h30);
    t1 = c[3];
    wr(5'h0D, 8'h00);
    wr(5'h0E, 8'h00);
    wr(5'h0F, 8'h00);
    wr(5'h10, 8'h00);
    repeat (2600) @(posedge clk);
    #1;
    frame(8'h30);
    check({7'h0, c[3] < t1}, 8'h01);
    wr(5'h09, 8'h27);
    wr(5'h0C, 8'h00);
    repeat (2600) @(posedge clk);
    #1;
    frame(8'h30);
    check({7'h0, c[3] == 2}, 8'h01);
    final_report;
  end
endmodule
